/* File: rtl/odsfc_chan.sv */
/*
  One driver channel: command decode, drive, diagnostic sink enable and
  latched fault flags.
  Assumes synchronised detector inputs and a command held steady.
*/
`timescale 1ns/10ps
module odsfc_chan
  import odsfc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic [1:0] cmd,
  input  wire logic       run,
  input  wire logic       limp,
  input  wire logic       limp_drive,
  input  wire logic       par_in,
  input  wire logic       powerup,
  input  wire logic       flt_clr,
  // Detectors
  input  wire logic       det_open,
  input  wire logic       det_over,
  // Results
  output logic            drive_r,
  output logic            sink_r,
  output odsfc_flt_s      flt_r
);

  logic standby;
  logic want_on;
  logic drive_nxt;
  logic sink_nxt;

  // Command decode; limp mode bypasses the serial command
  always_comb begin
    standby   = !limp && (cmd == CMD_STANDBY);
    want_on   = limp ? limp_drive :
                ((cmd == CMD_ON) || ((cmd == CMD_INPUT) && par_in));
    drive_nxt = run && want_on && !flt_r.overload_overtemp;
    sink_nxt  = run && !limp && !want_on &&
                (((cmd == CMD_OFF) && !powerup) || (cmd == CMD_INPUT));
  end

  // Drive and diagnostic sink
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_r <= 1'b0;
      sink_r  <= 1'b0;
    end else begin
      drive_r <= drive_nxt;
      sink_r  <= sink_nxt;
    end
  end

  // Latched faults; a detection wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flt_r <= '0;
    end else begin
      if (det_over && drive_r) begin
        flt_r.overload_overtemp <= 1'b1;
      end else if (flt_clr || standby) begin
        flt_r.overload_overtemp <= 1'b0;
      end
      if (det_open && sink_r && !drive_r) begin
        flt_r.open_load <= 1'b1;
      end else if (flt_clr || standby) begin
        flt_r.open_load <= 1'b0;
      end
    end
  end

endmodule

/* File: rtl/odsfc_pkg.sv */
/*
  Constants, encodings and carrier types for the serial control port of
  the eight-channel low-side driver.
  Assumes nothing of its surroundings; imported by every design file.
*/
// How it works
// - Power-up: global off, diagnostic sinks disabled
// - Two registers: command input, diagnostic output
// - Faults clear: standby, reset, enable low, limp exit
// - Sixteen-bit words, MSB first, two bits/channel
// - Bad bit count sets the frame error flag
// - Error flag on output until first rising edge
// - Flag also set on lockout, limp, quiescent exit (code: quiescent exit into active only)
// - Flag cleared only by a good frame
// - Flag window output ORs flag with serial input
// - Chip-select fall alone presents the flag
// - Sample input falling, shift output rising
// - Latch command only on good frame length
// - Counter armed by select fall, counts rising
// - First sixteen bits out are the diagnostics
// - Received words pass on one word later
// - Accept sixteen bits plus further eight-bit words
// - Ignore serial traffic while deselected
// - Reset sets all command bits to one
// - Commands: standby, parallel input, on, off
// - Open-load odd bits, overload even bits
// - Overload latches channel off until cleared
package odsfc_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CH    = 8;
  localparam int NUM_PAR   = 4;
  localparam int WORD_BITS = 16;

  // Frame length checking: bits within a byte, bytes counted
  localparam logic [2:0] BIT_IN_BYTE_LAST = 3'h7;
  localparam logic [2:0] BIT_IN_BYTE_ZERO = 3'h0;
  localparam logic [2:0] BIT_IN_BYTE_ONE  = 3'h1;
  localparam logic [1:0] BYTES_ZERO       = 2'h0;
  localparam logic [1:0] BYTES_MIN        = 2'h2;
  localparam logic [1:0] BYTES_SAT        = 2'h3;

  // ************************************************************
  // Channel command encodings and reset values
  // ************************************************************
  localparam logic [1:0] CMD_STANDBY = 2'h0;
  localparam logic [1:0] CMD_INPUT   = 2'h1;
  localparam logic [1:0] CMD_ON      = 2'h2;
  localparam logic [1:0] CMD_OFF     = 2'h3;
  localparam logic [15:0] CMD_WORD_RESET = 16'hFFFF;
  localparam logic [15:0] DIAG_WORD_RESET = 16'h0000;

  // Operating states, one-hot
  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'h1,
    ST_LOWQ    = 4'h2,
    ST_ACTIVE  = 4'h4,
    ST_LIMP    = 4'h8
  } odsfc_state_e;

  // Per-channel fault pair, as it sits in the diagnostic word
  typedef struct packed {
    logic open_load;
    logic overload_overtemp;
  } odsfc_flt_s;

  // Frame summary handed from the link side at chip-select rise
  typedef struct packed {
    logic [15:0] data;
    logic [2:0]  bit_in_byte;
    logic [1:0]  bytes;
  } odsfc_frame_s;

endpackage

/* File: rtl/odsfc_sync.sv */
/*
  Two-flop level synchroniser, width set by parameter.
  Assumes inputs are levels from another clock domain or from pins.
*/
`timescale 1ns/10ps
module odsfc_sync
  import odsfc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: rtl/odsfc_top.sv */
/*
  Serial control port of the eight-channel low-side driver: link-side
  shift logic on the serial clock, frame check, command register, fault
  word, frame error flag and operating state on the system clock.
  Assumes the host keeps the serial clock low around chip-select edges
  and leaves chip select high for at least three system clocks.
*/
`timescale 1ns/10ps
module odsfc_top
  import odsfc_pkg::*;
(
  // System clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RST_B,
  // Serial link
  input  wire logic               SCLK,
  input  wire logic               CSB_I,
  input  wire logic               SI_I,
  output logic                    SO_O,
  output logic                    SO_OE,
  // Mode pins
  input  wire logic               EN_I,
  input  wire logic               LIMP_HOME_INPUT_I,
  input  wire logic               UNDERVOLTAGE_LOCKOUT_I,
  input  wire logic [NUM_PAR-1:0] PARALLEL_DRIVE_INPUT_I,
  // Fault detectors
  input  wire logic [NUM_CH-1:0]  OPEN_LOAD_DET_I,
  input  wire logic [NUM_CH-1:0]  OVERLOAD_OVERTEMP_DET_I,
  // Driver controls
  output logic      [NUM_CH-1:0]  DRIVER_OUTPUT_O,
  output logic      [NUM_CH-1:0]  DIAG_SINK_EN_O,
  // Status
  output logic      [NUM_CH-1:0]  OPEN_LOAD_FLAG_O,
  output logic      [NUM_CH-1:0]  OVERLOAD_OVERTEMP_FLAG_O,
  output logic                    FRAME_ERROR_FLAG_O,
  output logic                    LOW_QUIESCENT_STATE_O,
  output logic      [15:0]        COMMAND_WORD_O
);

  // ************************************************************
  // Link-side logic on the serial clock
  // ************************************************************

  logic                    frame_rst_b;
  logic                    started_r;
  logic                    fell_r;
  logic [2:0]              bit_in_byte_r;
  logic [1:0]              bytes_r;
  logic                    frame_tog_r;
  logic                    so_shift_r;
  logic [WORD_BITS-1:0]    shift_r;
  logic [WORD_BITS-1:0]    diag_snap_r;
  logic                    so_win_r;

  // Frame-scoped flags are cleared while deselected
  assign frame_rst_b = RST_B & ~CSB_I;

  // Marks that the first rising edge of the frame has happened
  always_ff @(posedge SCLK or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
    end
  end

  // Marks that the first falling edge of the frame has happened
  always_ff @(negedge SCLK or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      fell_r <= 1'b0;
    end else begin
      fell_r <= 1'b1;
    end
  end

  // Bit counter: modulo-8 position plus saturating byte count
  always_ff @(posedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_in_byte_r <= BIT_IN_BYTE_ZERO;
      bytes_r       <= BYTES_ZERO;
    end else if (!started_r) begin
      bit_in_byte_r <= BIT_IN_BYTE_ONE;
      bytes_r       <= BYTES_ZERO;
    end else begin
      bit_in_byte_r <= bit_in_byte_r + BIT_IN_BYTE_ONE;
      if ((bit_in_byte_r == BIT_IN_BYTE_LAST) && (bytes_r != BYTES_SAT)) begin
        bytes_r <= bytes_r + 2'h1;
      end
    end
  end

  // Toggles once per selected frame that saw a rising clock edge; clocks while
  // deselected must not count as a frame
  always_ff @(posedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      frame_tog_r <= 1'b0;
    end else if (!started_r && !CSB_I) begin
      frame_tog_r <= ~frame_tog_r;
    end
  end

  // Output bit: fault word MSB first, then bits received one word earlier
  always_ff @(posedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      so_shift_r <= 1'b0;
    end else begin
      so_shift_r <= started_r ? shift_r[WORD_BITS-1] : diag_snap_r[WORD_BITS-1];
    end
  end

  // Input sampling on the falling edge; first fall loads the fault word
  always_ff @(negedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_r <= DIAG_WORD_RESET;
    end else if (!fell_r) begin
      shift_r <= {diag_snap_r[WORD_BITS-2:0], SI_I};
    end else begin
      shift_r <= {shift_r[WORD_BITS-2:0], SI_I};
    end
  end

  // ************************************************************
  // Synchronisers into the system clock
  // ************************************************************

  localparam int SYNC_W = 6 + NUM_PAR + 2 * NUM_CH;

  logic [SYNC_W-1:0]  sync_d;
  logic [SYNC_W-1:0]  sync_q;
  logic               s_csb;
  logic               s_si;
  logic               s_en;
  logic               s_limp;
  logic               s_undervoltage_lockout;
  logic               s_tog;
  logic [NUM_PAR-1:0] s_par;
  logic [NUM_CH-1:0]  s_open;
  logic [NUM_CH-1:0]  s_over;
  logic               s_sel;
  logic               s_supply_ok;

  // Select and lockout cross inverted, so that the synchroniser's reset
  // value reads as deselected and locked out until the pins are seen
  assign sync_d = {~CSB_I, SI_I, EN_I, LIMP_HOME_INPUT_I, ~UNDERVOLTAGE_LOCKOUT_I,
                   frame_tog_r, PARALLEL_DRIVE_INPUT_I, OPEN_LOAD_DET_I,
                   OVERLOAD_OVERTEMP_DET_I};

  odsfc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .d     (sync_d),
    .q     (sync_q)
  );

  assign {s_sel, s_si, s_en, s_limp, s_supply_ok, s_tog, s_par, s_open, s_over} = sync_q;
  assign s_csb  = ~s_sel;
  assign s_undervoltage_lockout = ~s_supply_ok;

  // ************************************************************
  // Frame end detection and check
  // ************************************************************

  logic         csb_d_r;
  logic         tog_seen_r;
  logic         csb_rise;
  logic         csb_fall;
  logic         frame_seen;
  logic         frame_good;
  logic         frame_bad;
  odsfc_frame_s frame;

  // Previous select level and last frame toggle seen
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      csb_d_r    <= 1'b1;
      tog_seen_r <= 1'b0;
    end else begin
      csb_d_r <= s_csb;
      if (csb_rise) begin
        tog_seen_r <= s_tog;
      end
    end
  end

  // Link counters and data are still at select rise: the clock is idle
  always_comb begin
    frame.data        = shift_r;
    frame.bit_in_byte = bit_in_byte_r;
    frame.bytes       = bytes_r;
    csb_rise   = s_csb && !csb_d_r;
    csb_fall   = !s_csb && csb_d_r;
    frame_seen = csb_rise && (s_tog != tog_seen_r);
    frame_good = frame_seen && (frame.bit_in_byte == BIT_IN_BYTE_ZERO) &&
                 (frame.bytes >= BYTES_MIN);
    frame_bad  = frame_seen && !frame_good;
  end

  // ************************************************************
  // Operating state
  // ************************************************************

  odsfc_state_e state_r;
  odsfc_state_e state_nxt;
  logic         to_active;
  logic         leave_limp;

  // Mode transitions from the supply monitor, enable and limp pins
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_LOCKOUT: begin
        if (!s_undervoltage_lockout) begin
          state_nxt = s_limp ? ST_LIMP : (s_en ? ST_ACTIVE : ST_LOWQ);
        end
      end
      ST_LOWQ: begin
        if (s_undervoltage_lockout) begin
          state_nxt = ST_LOCKOUT;
        end else if (s_limp) begin
          state_nxt = ST_LIMP;
        end else if (s_en) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (s_undervoltage_lockout) begin
          state_nxt = ST_LOCKOUT;
        end else if (s_limp) begin
          state_nxt = ST_LIMP;
        end else if (!s_en) begin
          state_nxt = ST_LOWQ;
        end
      end
      ST_LIMP: begin
        if (s_undervoltage_lockout) begin
          state_nxt = ST_LOCKOUT;
        end else if (!s_limp) begin
          state_nxt = s_en ? ST_ACTIVE : ST_LOWQ;
        end
      end
      default: begin
        state_nxt = ST_LOCKOUT;
      end
    endcase
    to_active  = (state_nxt == ST_ACTIVE) && (state_r != ST_ACTIVE);
    leave_limp = (state_r == ST_LIMP) && (state_nxt != ST_LIMP);
  end

  // State register; power-up starts in lockout
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_LOCKOUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Command register, power-up flag and frame error flag
  // ************************************************************

  logic [15:0] cmd_r;
  logic        powerup_r;
  logic        ter_r;
  logic        regs_reset;
  logic        accept;

  // Registers return to reset values on leaving lockout or limp
  assign regs_reset = ((state_r == ST_LOCKOUT) && (state_nxt != ST_LOCKOUT)) || leave_limp;
  assign accept     = frame_good && (state_r == ST_ACTIVE);

  // Input register: all ones after reset, last 16 bits on a good frame in active state
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cmd_r     <= CMD_WORD_RESET;
      powerup_r <= 1'b1;
    end else if (regs_reset) begin
      cmd_r     <= CMD_WORD_RESET;
      powerup_r <= 1'b1;
    end else if (accept) begin
      cmd_r     <= frame.data;
      powerup_r <= 1'b0;
    end
  end

  // Frame error flag: any setting event wins over a clear
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ter_r <= 1'b1;
    end else if (frame_bad || regs_reset || to_active) begin
      ter_r <= 1'b1;
    end else if (accept) begin
      ter_r <= 1'b0;
    end
  end

  // ************************************************************
  // Channels and fault word
  // ************************************************************

  logic [NUM_CH-1:0]  drive;
  logic [NUM_CH-1:0]  sink;
  odsfc_flt_s [NUM_CH-1:0] flt;
  logic               run;
  logic               limp;
  logic               flt_clr;

  assign run     = (state_r == ST_ACTIVE) || (state_r == ST_LIMP);
  assign limp    = (state_r == ST_LIMP);
  assign flt_clr = !run || leave_limp;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      odsfc_chan u_chan (
        .clk        (CLK_SYS),
        .rst_b      (RST_B),
        .cmd        (cmd_r[2*gi+1:2*gi]),
        .run        (run),
        .limp       (limp),
        .limp_drive ((gi < NUM_PAR) ? s_par[gi % NUM_PAR] : 1'b0),
        .par_in     (s_par[gi % NUM_PAR]),
        .powerup    (powerup_r),
        .flt_clr    (flt_clr),
        .det_open   (s_open[gi]),
        .det_over   (s_over[gi]),
        .drive_r    (drive[gi]),
        .sink_r     (sink[gi]),
        .flt_r      (flt[gi])
      );
    end
  endgenerate

  // Fault word snapshot, frozen while selected
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      diag_snap_r <= DIAG_WORD_RESET;
    end else if (s_csb) begin
      diag_snap_r <= flt;
    end
  end

  // ************************************************************
  // Serial output
  // ************************************************************

  // Flag window value and output enable
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      so_win_r <= 1'b0;
      SO_OE    <= 1'b0;
    end else begin
      so_win_r <= ter_r | s_si;
      SO_OE    <= !s_csb;
    end
  end

  // Flag until the first rising edge, then the shifted data
  assign SO_O = started_r ? so_shift_r : so_win_r;

  // ************************************************************
  // Registered status outputs
  // ************************************************************

  // Status and driver outputs
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      DRIVER_OUTPUT_O          <= '0;
      DIAG_SINK_EN_O           <= '0;
      OPEN_LOAD_FLAG_O         <= '0;
      OVERLOAD_OVERTEMP_FLAG_O <= '0;
      FRAME_ERROR_FLAG_O       <= 1'b1;
      LOW_QUIESCENT_STATE_O    <= 1'b0;
      COMMAND_WORD_O           <= CMD_WORD_RESET;
    end else begin
      DRIVER_OUTPUT_O <= drive;
      DIAG_SINK_EN_O  <= sink;
      for (int i = 0; i < NUM_CH; i++) begin
        OPEN_LOAD_FLAG_O[i]         <= flt[i].open_load;
        OVERLOAD_OVERTEMP_FLAG_O[i] <= flt[i].overload_overtemp;
      end
      FRAME_ERROR_FLAG_O    <= ter_r;
      LOW_QUIESCENT_STATE_O <= (state_r == ST_LOWQ);
      COMMAND_WORD_O        <= cmd_r;
    end
  end

endmodule

/* File: verification/odsfc_host.sv */
/*
  Host controller model: drives chip select, serial clock and serial input.
  Assumes SO is the resolved line level; the clock stands still between frames.
*/
`timescale 1ns/10ps
module odsfc_host (
  // Serial lines
  output logic      sclk,
  output logic      csb,
  output logic      si,
  input  wire logic so
);
  // ************************************************************
  // Frame driver, 12 ns serial clock
  // ************************************************************
  initial begin
    sclk = 1'b0;
    csb  = 1'b1;
    si   = 1'b0;
  end
  // Select, read the window bit, clock n bits, deselect
  task automatic xfer(input int n, input logic [63:0] tx, input logic sel,
                      input logic si_win, output logic [63:0] rx, output logic flag);
    rx = '0;
    si = si_win;
    csb = ~sel;
    #28;
    flag = so;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      si = tx[i];
      #6;
      rx = {rx[62:0], so};
      sclk = 1'b0;
      #6;
    end
    csb = 1'b1;
    si = ~si; // Released line does not keep its level
    #60;
  endtask
endmodule

/* File: verification/odsfc_monitor.sv */
/*
  Concurrent checks on the serial control port.
  Assumes it is bound to odsfc_top and sees only its ports.
*/
`timescale 1ns/10ps
module odsfc_monitor
  import odsfc_pkg::*;
(
  // Clock, reset and serial link
  input wire logic              CLK_SYS,
  input wire logic              RST_B,
  input wire logic              SCLK,
  input wire logic              CSB_I,
  input wire logic              SI_I,
  input wire logic              SO_O,
  input wire logic              SO_OE,
  // Mode pin and detectors
  input wire logic              EN_I,
  input wire logic [NUM_CH-1:0] OPEN_LOAD_DET_I,
  input wire logic [NUM_CH-1:0] OVERLOAD_OVERTEMP_DET_I,
  // Results
  input wire logic [NUM_CH-1:0] DRIVER_OUTPUT_O,
  input wire logic [NUM_CH-1:0] DIAG_SINK_EN_O,
  input wire logic [NUM_CH-1:0] OPEN_LOAD_FLAG_O,
  input wire logic [NUM_CH-1:0] OVERLOAD_OVERTEMP_FLAG_O,
  input wire logic              FRAME_ERROR_FLAG_O,
  input wire logic [15:0]       COMMAND_WORD_O
);
  // ************************************************************
  // Checks on the system clock
  // ************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Output driven while selected, released otherwise
  a_oe_select: assert property (!CSB_I [*4] |-> SO_OE)
    else $error("SO_OE low while selected");
  a_oe_release: assert property (CSB_I [*4] |-> !SO_OE)
    else $error("SO_OE high while deselected");
  // Window bit is the flag ORed with the serial input
  a_flag_window: assert property ((!CSB_I && !SCLK && !SI_I) [*6] |->
    SO_O == FRAME_ERROR_FLAG_O)
    else $error("window bit differs from flag");
  a_or_input: assert property ((!CSB_I && !SCLK && SI_I) [*6] |-> SO_O)
    else $error("window bit ignores serial input");
  // Values right after reset
  a_reset_values: assert property ($rose(RST_B) |-> FRAME_ERROR_FLAG_O &&
    DIAG_SINK_EN_O == 8'h00 && COMMAND_WORD_O == CMD_WORD_RESET)
    else $error("wrong values after reset");
  // Command changes only after a frame that cleared the flag, or returns to all-off
  a_cmd_hold: assert property ($changed(COMMAND_WORD_O) |->
    COMMAND_WORD_O == CMD_WORD_RESET || ($past(CSB_I, 2) && !FRAME_ERROR_FLAG_O))
    else $error("command changed without good frame");
  a_flag_clear: assert property ($fell(FRAME_ERROR_FLAG_O) |-> $past(CSB_I, 2))
    else $error("flag cleared inside a frame");
  // Enable low clears faults outside limp; a latched overload keeps its channel off
  a_fault_clear: assert property ((!EN_I && OPEN_LOAD_DET_I == 8'h00 &&
    OVERLOAD_OVERTEMP_DET_I == 8'h00) [*8] |->
    OPEN_LOAD_FLAG_O == 8'h00 && OVERLOAD_OVERTEMP_FLAG_O == 8'h00)
    else $error("faults kept with enable low");
  a_latch_off: assert property ((OVERLOAD_OVERTEMP_FLAG_O &
    $past(OVERLOAD_OVERTEMP_FLAG_O) & DRIVER_OUTPUT_O) == 8'h00)
    else $error("channel on with overload latched");
  // Main scenarios
  c_flag_clear: cover property ($fell(FRAME_ERROR_FLAG_O));
  c_overload: cover property ($rose(OVERLOAD_OVERTEMP_FLAG_O[0]));
  c_command: cover property ($changed(COMMAND_WORD_O));
endmodule

bind odsfc_top odsfc_monitor u_odsfc_monitor (.CLK_SYS, .RST_B, .SCLK, .CSB_I, .SI_I, .SO_O,
  .SO_OE, .EN_I, .OPEN_LOAD_DET_I, .OVERLOAD_OVERTEMP_DET_I, .DRIVER_OUTPUT_O, .DIAG_SINK_EN_O,
  .OPEN_LOAD_FLAG_O, .OVERLOAD_OVERTEMP_FLAG_O, .FRAME_ERROR_FLAG_O, .COMMAND_WORD_O);

/* File: verification/odsfc_top_tb.sv */
/*
  Self-checking bench for the serial control port.
  Assumes odsfc_host as the far side and the bound monitor.
*/
`timescale 1ns/10ps
module odsfc_top_tb
  import odsfc_pkg::*;
;
  // ************************************************************
  // Signals, clock and instances
  // ************************************************************
  typedef struct {int n; logic [63:0] tx; logic flag;
                  logic [15:0] cmd; logic [7:0] drv;} odsfc_row_s;
  logic        CLK_SYS = 1'b0;
  logic        RST_B = 1'b0;
  logic        EN_I = 1'b1;
  logic        LIMP_HOME_INPUT_I = 1'b0;
  logic        UNDERVOLTAGE_LOCKOUT_I = 1'b0;
  logic [3:0]  PARALLEL_DRIVE_INPUT_I = 4'h5;
  logic [7:0]  OPEN_LOAD_DET_I = 8'h00;
  logic [7:0]  OVERLOAD_OVERTEMP_DET_I = 8'h00;
  logic        SCLK, CSB_I, SI_I, SO_O, SO_OE, FRAME_ERROR_FLAG_O, LOW_QUIESCENT_STATE_O, flg;
  logic [7:0]  DRIVER_OUTPUT_O, DIAG_SINK_EN_O, OPEN_LOAD_FLAG_O, OVERLOAD_OVERTEMP_FLAG_O;
  logic [15:0] COMMAND_WORD_O, m;
  logic [63:0] rx;
  wire         so_line = SO_OE ? SO_O : ~SO_O;
  int          fail_count = 0;
  int          comparisons = 0;
  odsfc_row_s  rows [7];
  always #2 CLK_SYS = ~CLK_SYS;
  odsfc_top u_odsfc_top (.CLK_SYS, .RST_B, .SCLK, .CSB_I, .SI_I, .SO_O, .SO_OE, .EN_I,
    .LIMP_HOME_INPUT_I, .UNDERVOLTAGE_LOCKOUT_I, .PARALLEL_DRIVE_INPUT_I, .OPEN_LOAD_DET_I,
    .OVERLOAD_OVERTEMP_DET_I, .DRIVER_OUTPUT_O, .DIAG_SINK_EN_O, .OPEN_LOAD_FLAG_O,
    .OVERLOAD_OVERTEMP_FLAG_O, .FRAME_ERROR_FLAG_O, .LOW_QUIESCENT_STATE_O, .COMMAND_WORD_O);
  odsfc_host u_odsfc_host (.sclk(SCLK), .csb(CSB_I), .si(SI_I), .so(so_line));
  // Compare, frame and wait helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fr(input int n, input logic [63:0] tx, input logic sel, input logic sw);
    u_odsfc_host.xfer(n, tx, sel, sw, rx, flg);
  endtask
  task automatic rdflag(input logic exp);
    fr(0, 64'h0, 1'b1, 1'b0);
    chk("flag", {15'h0000, exp}, {15'h0000, flg});
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rows = '{'{16, 64'hAAAA, 1'b0, 16'hAAAA, 8'hFF}, '{12, 64'h0, 1'b1, 16'hAAAA, 8'hFF},
             '{24, 64'hC35555, 1'b0, 16'h5555, 8'h55}, '{20, 64'hF0000, 1'b1, 16'h5555, 8'h55},
             '{32, 64'hABCD0000, 1'b0, 16'h0000, 8'h00}, '{17, 64'h1FFFF, 1'b1, 16'h0000, 8'h00},
             '{40, 64'h123456FFFF, 1'b0, 16'hFFFF, 8'h00}};
    waitc(10);
    RST_B = 1'b1;
    chk("cmd_reset", CMD_WORD_RESET, COMMAND_WORD_O);
    chk("sink_reset", 16'h0000, {8'h00, DIAG_SINK_EN_O});
    waitc(10);
    rdflag(1'b1);
    $display("test reset done");
    foreach (rows[k]) begin
      fr(rows[k].n, rows[k].tx, 1'b1, 1'b0);
      m = 16'((64'h1 << (rows[k].n - 16)) - 64'h1);
      if (rows[k].n >= 16) chk("diag", 16'h0000, 16'(rx >> (rows[k].n - 16)));
      if (rows[k].n > 16) chk("pass", 16'(rows[k].tx >> 16) & m, rx[15:0] & m);
      rdflag(rows[k].flag);
      chk("cmd", rows[k].cmd, COMMAND_WORD_O);
      chk("drive", {8'h00, rows[k].drv}, {8'h00, DRIVER_OUTPUT_O});
    end
    $display("test frames done");
    fr(16, 64'hAAEA, 1'b1, 1'b0);
    waitc(2);
    OVERLOAD_OVERTEMP_DET_I = 8'h01;
    OPEN_LOAD_DET_I = 8'h08;
    waitc(10);
    OVERLOAD_OVERTEMP_DET_I = 8'h00;
    OPEN_LOAD_DET_I = 8'h00;
    waitc(4);
    chk("ov_flag", 16'h0001, {8'h00, OVERLOAD_OVERTEMP_FLAG_O});
    chk("ol_flag", 16'h0008, {8'h00, OPEN_LOAD_FLAG_O});
    chk("drv_off", 16'h00F6, {8'h00, DRIVER_OUTPUT_O});
    fr(16, 64'hAAEA, 1'b1, 1'b0);
    chk("diag_word", 16'h0081, rx[15:0]);
    fr(16, 64'h0000, 1'b1, 1'b0);
    chk("flt_clear", 16'h0000, {OPEN_LOAD_FLAG_O, OVERLOAD_OVERTEMP_FLAG_O});
    $display("test faults done");
    fr(17, 64'h15555, 1'b0, 1'b0);
    chk("deselect", 16'h0000, COMMAND_WORD_O);
    fr(0, 64'h0, 1'b1, 1'b1);
    chk("or_si", 16'h0001, {15'h0000, flg});
    rdflag(1'b0);
    $display("test link done");
    EN_I = 1'b0;
    waitc(10);
    chk("low_q", 16'h0001, {15'h0000, LOW_QUIESCENT_STATE_O});
    EN_I = 1'b1;
    waitc(10);
    rdflag(1'b1);
    fr(16, 64'hFFFF, 1'b1, 1'b0);
    rdflag(1'b0);
    waitc(1);
    LIMP_HOME_INPUT_I = 1'b1;
    PARALLEL_DRIVE_INPUT_I = 4'hF;
    waitc(10);
    chk("limp_drive", 16'h000F, {8'h00, DRIVER_OUTPUT_O});
    LIMP_HOME_INPUT_I = 1'b0;
    waitc(10);
    rdflag(1'b1);
    fr(16, 64'hFFFF, 1'b1, 1'b0);
    waitc(1);
    UNDERVOLTAGE_LOCKOUT_I = 1'b1;
    waitc(10);
    UNDERVOLTAGE_LOCKOUT_I = 1'b0;
    waitc(10);
    rdflag(1'b1);
    $display("test modes done");
    fr(16, 64'h5555, 1'b1, 1'b0);
    chk("cmd_pre", 16'h5555, COMMAND_WORD_O);
    waitc(1);
    RST_B = 1'b0;
    waitc(3);
    chk("cmd_rst2", CMD_WORD_RESET, COMMAND_WORD_O);
    RST_B = 1'b1;
    waitc(10);
    rdflag(1'b1);
    $display("test reset again done");
    stop_test();
  end
endmodule
